// ---- hw/tfad_decode.sv ----
/*
  Task-file access decoder: samples host chip selects, address and strobes,
  and turns them into register actions, PIO and Multiword DMA word moves.
  Assumes the device core supplies Status, Error, DMARQ state and data words
  on the same clock, and that the bench resolves the data bus from dd_oe_n.
*/
`timescale 1ns/1ps
module tfad_decode
  import tfad_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Host pins, asynchronous
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic dmack_n,
  input wire logic [15:0] dd_in,
  output logic [15:0] dd_out,
  output logic dd_oe_n,
  // Device core state
  input wire logic [7:0] status_in,
  input wire logic [7:0] error_in,
  input wire logic dmarq_on,
  input wire logic dmarq_released,
  input wire logic [15:0] rd_word,
  input wire logic int_req,
  // Configuration
  input wire logic dev_num,
  input wire logic dev1_absent,
  input wire logic devrst_supported,
  // Register contents
  output logic [7:0] cyl_high,
  output logic [7:0] dev_head,
  output logic [7:0] features,
  output logic [7:0] command,
  output logic nien,
  output logic srst,
  output logic selected,
  output logic int_pending,
  // Event pulses and written word
  output logic cmd_start,
  output logic pio_rd,
  output logic pio_wr,
  output logic dma_rd,
  output logic dma_wr,
  output logic host_fault,
  output logic [15:0] wr_word
);

  typedef struct packed {
    logic [23:0] sy1;      // First synchroniser stage
    logic [23:0] sy2;      // Second stage, the only one logic reads
    logic dior_q;          // Previous synced DIOR-
    logic diow_q;          // Previous synced DIOW-
    logic [7:0] cyl_high;
    logic [7:0] dev_head;
    logic [7:0] features;
    logic [7:0] command;
    logic nien;
    logic srst;
    logic selected;
    logic int_pend;
    logic burst;           // A DMA word moved with DMARQ asserted since DMACK- asserted; the trailing word clears it
    logic oe_n;
    logic [15:0] dout;
    logic cmd_start;
    logic pio_rd;
    logic pio_wr;
    logic dma_rd;
    logic dma_wr;
    logic fault;
    logic [15:0] wword;
  } tfad_st_t;

  tfad_st_t st_r;
  tfad_st_t st_nxt;

  // Decoded views of the synchronised pins
  logic bsy, drq, rd_ev, wr_ev, ev, cb, ctl, both_cs, dmack, resp1, idle;
  logic [2:0] a;
  logic [15:0] din;

  // Strobe edges: read acts on assertion, write on release when data is stable
  always_comb
  begin
    bsy = status_in[TFAD_ST_BSY];
    drq = status_in[TFAD_ST_DRQ];
    idle = !bsy && !drq;
    a = st_r.sy2[TFAD_B_DA +: 3];
    din = st_r.sy2[15:0];
    dmack = !st_r.sy2[TFAD_B_DMACK];
    cb = !st_r.sy2[TFAD_B_CS0] && st_r.sy2[TFAD_B_CS1];
    ctl = st_r.sy2[TFAD_B_CS0] && !st_r.sy2[TFAD_B_CS1];
    both_cs = !st_r.sy2[TFAD_B_CS0] && !st_r.sy2[TFAD_B_CS1];
    rd_ev = !st_r.sy2[TFAD_B_DIOR] && st_r.dior_q;
    wr_ev = st_r.sy2[TFAD_B_DIOW] && !st_r.diow_q;
    ev = rd_ev || wr_ev;
    // Device 0 stands in for an absent Device 1
    resp1 = dev1_absent && !dev_num && st_r.dev_head[TFAD_DH_DEV];
  end

  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sy1 = {cs0_n, cs1_n, da, dior_n, diow_n, dmack_n, dd_in};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.dior_q = st_r.sy2[TFAD_B_DIOR];
    st_nxt.diow_q = st_r.sy2[TFAD_B_DIOW];
    st_nxt.cmd_start = 1'b0;
    st_nxt.pio_rd = 1'b0;
    st_nxt.pio_wr = 1'b0;
    st_nxt.dma_rd = 1'b0;
    st_nxt.dma_wr = 1'b0;
    st_nxt.fault = 1'b0;
    st_nxt.selected = (st_r.dev_head[TFAD_DH_DEV] == dev_num); // [RL14]
    // Bus is released the cycle after the synchronised DIOR- shows the host has let it go
    if (st_r.sy2[TFAD_B_DIOR])
    begin
      st_nxt.oe_n = 1'b1;
    end
    if (!dmack)
    begin
      st_nxt.burst = 1'b0;
    end
    if (dmack)
    begin
      // DMA window: chip selects must stay negated
      if (ev && !cb && !ctl && !both_cs)
      begin
        if (dmarq_on && !dmarq_released && (bsy || drq)) // [RL12]
        begin
          st_nxt.dma_rd = rd_ev;
          st_nxt.dma_wr = wr_ev;
          st_nxt.burst = 1'b1;
          st_nxt.wword = din;
          if (rd_ev)
          begin
            st_nxt.dout = rd_word;
            st_nxt.oe_n = 1'b0;
          end
        end
        else if (!dmarq_on && !dmarq_released && (bsy || drq) && st_r.burst) // [RL11]
        begin
          // Final word of the burst; a further strobe is a fault
          st_nxt.dma_rd = rd_ev;
          st_nxt.dma_wr = wr_ev;
          st_nxt.burst = 1'b0;
          st_nxt.wword = din;
          if (rd_ev)
          begin
            st_nxt.dout = rd_word;
            st_nxt.oe_n = 1'b0;
          end
        end
        else
        begin
          st_nxt.fault = 1'b1; // [RL10]
        end
      end
      else if (ev)
      begin
        st_nxt.fault = 1'b1; // [RL13]
      end
    end
    else if (ev && both_cs)
    begin
      // Both selects asserted: nothing happens at all [RL9]
    end
    else if (ev && cb && (st_r.selected || resp1))
    begin
      if (rd_ev)
      begin
        st_nxt.oe_n = 1'b0;
        if (resp1 && !st_r.selected)
        begin
          st_nxt.dout = TFAD_ZERO_WORD;
        end
        else if (a == TFAD_A_CMDSTAT)
        begin
          st_nxt.dout = {8'h00, status_in}; // [RL8]
          st_nxt.int_pend = 1'b0;
        end
        else if (bsy)
        begin
          st_nxt.dout = {8'h00, status_in}; // [RL2]
        end
        else
        begin
          unique case (a)
            TFAD_A_DATA:
            begin
              if (drq)
              begin
                st_nxt.dout = rd_word; // [RL16]
                st_nxt.pio_rd = 1'b1;
              end
              else
              begin
                st_nxt.dout = TFAD_ZERO_WORD;
              end
            end
            TFAD_A_ERRFEAT: st_nxt.dout = {8'h00, error_in}; // [RL17]
            TFAD_A_CYLHI: st_nxt.dout = {8'h00, st_r.cyl_high}; // [RL1]
            TFAD_A_DEVHEAD: st_nxt.dout = {8'h00, st_r.dev_head}; // [RL5]
            default: st_nxt.dout = TFAD_ZERO_WORD; // Other registers live elsewhere
          endcase
        end
      end
      else if (a == TFAD_A_CMDSTAT)
      begin
        if (st_r.selected && (idle || (devrst_supported
            && din[7:0] == TFAD_CMD_DEVRST))) // [RL6] [RL7]
        begin
          st_nxt.command = din[7:0];
          st_nxt.cmd_start = 1'b1;
          st_nxt.int_pend = 1'b0;
        end
        else if (!bsy && drq)
        begin
          st_nxt.fault = 1'b1; // [RL4]
        end
      end
      else if (bsy)
      begin
        // Busy: the write is dropped [RL2]
      end
      else if (a == TFAD_A_DATA)
      begin
        if (drq)
        begin
          st_nxt.pio_wr = 1'b1; // [RL16]
          st_nxt.wword = din;
        end
      end
      else if (drq)
      begin
        st_nxt.fault = 1'b1; // [RL4]
      end
      else
      begin
        unique case (a)
          TFAD_A_ERRFEAT: st_nxt.features = din[7:0];
          TFAD_A_CYLHI: st_nxt.cyl_high = din[7:0];
          TFAD_A_DEVHEAD: st_nxt.dev_head = din[7:0]; // [RL3]
          default: st_nxt.wword = st_r.wword; // Other registers live elsewhere
        endcase
      end
    end
    else if (ev && cb && wr_ev && a == TFAD_A_DEVHEAD && idle)
    begin
      // Unselected device still follows the DEV bit to reselect itself
      st_nxt.dev_head = din[7:0]; // [RL3]
    end
    else if (ev && ctl && a == TFAD_A_DEVCTL && (st_r.selected || resp1))
    begin
      if (wr_ev)
      begin
        st_nxt.nien = din[TFAD_DC_NIEN]; // [RL15]
        st_nxt.srst = din[TFAD_DC_SRST];
      end
      else
      begin
        st_nxt.oe_n = 1'b0;
        st_nxt.dout = st_r.selected ? {8'h00, status_in} : TFAD_ZERO_WORD;
      end
    end
    // A new interrupt wins over a clear in the same cycle
    if (int_req)
    begin
      st_nxt.int_pend = 1'b1;
    end
  end

  // State register; synchronisers reset to the idle pin level
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.sy1 <= TFAD_SYNC_RST;
      st_r.sy2 <= TFAD_SYNC_RST;
      st_r.dior_q <= 1'b1;
      st_r.diow_q <= 1'b1;
      st_r.oe_n <= 1'b1;
      st_r.dev_head <= TFAD_REG_RST;
      st_r.selected <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign dd_out = st_r.dout;
  assign dd_oe_n = st_r.oe_n;
  assign cyl_high = st_r.cyl_high;
  assign dev_head = st_r.dev_head;
  assign features = st_r.features;
  assign command = st_r.command;
  assign nien = st_r.nien;
  assign srst = st_r.srst;
  assign selected = st_r.selected;
  assign int_pending = st_r.int_pend;
  assign cmd_start = st_r.cmd_start;
  assign pio_rd = st_r.pio_rd;
  assign pio_wr = st_r.pio_wr;
  assign dma_rd = st_r.dma_rd;
  assign dma_wr = st_r.dma_wr;
  assign host_fault = st_r.fault;
  assign wr_word = st_r.wword;

  // Checks on the decoded behaviour
  logic sel_cb;
  assign sel_cb = !dmack && cb && st_r.selected;

  property p_cylhi_rd;
    @(posedge clock) disable iff (!rst_n)
    rd_ev && sel_cb && !bsy && a == TFAD_A_CYLHI |=> dd_out[7:0] == $past(st_r.cyl_high);
  endproperty
  a_cylhi_rd: assert property (p_cylhi_rd) else $error("cyl high read wrong"); // [RL1]

  property p_busy_rd;
    @(posedge clock) disable iff (!rst_n)
    rd_ev && sel_cb && bsy |=> dd_out[7:0] == $past(status_in) && !dd_oe_n;
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy read not status"); // [RL2]

  property p_dh_wr;
    @(posedge clock) disable iff (!rst_n)
    wr_ev && sel_cb && idle && a == TFAD_A_DEVHEAD
      |=> dev_head == $past(din[7:0]) ##1 selected == (dev_head[TFAD_DH_DEV] == dev_num);
  endproperty
  a_dh_wr: assert property (p_dh_wr) else $error("device/head write lost"); // [RL3] [RL14]

  property p_drq_wr;
    @(posedge clock) disable iff (!rst_n)
    wr_ev && sel_cb && !bsy && drq && a != TFAD_A_DATA
      && !(devrst_supported && a == TFAD_A_CMDSTAT && din[7:0] == TFAD_CMD_DEVRST)
      |=> host_fault && $stable(cyl_high);
  endproperty
  a_drq_wr: assert property (p_drq_wr) else $error("drq write not dropped"); // [RL4]

  property p_cmd_wr;
    @(posedge clock) disable iff (!rst_n)
    wr_ev && sel_cb && idle && a == TFAD_A_CMDSTAT && !int_req
      |=> cmd_start && !int_pending ##1 !cmd_start;
  endproperty
  a_cmd_wr: assert property (p_cmd_wr) else $error("command not started"); // [RL6]

  property p_stat_rd;
    @(posedge clock) disable iff (!rst_n)
    rd_ev && sel_cb && a == TFAD_A_CMDSTAT && !int_req
      |=> !int_pending && dd_out[7:0] == $past(status_in);
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read wrong"); // [RL8]

  property p_both_cs;
    @(posedge clock) disable iff (!rst_n)
    ev && !dmack && both_cs |=> !cmd_start && !pio_rd && !pio_wr && $stable(dev_head);
  endproperty
  a_both_cs: assert property (p_both_cs) else $error("both selects acted"); // [RL9]

  property p_dma_word;
    @(posedge clock) disable iff (!rst_n)
    ev && dmack && !cb && !ctl && !both_cs && dmarq_on && !dmarq_released && (bsy || drq)
      |=> (dma_rd || dma_wr) ##1 !dma_rd && !dma_wr;
  endproperty
  a_dma_word: assert property (p_dma_word) else $error("dma word not moved"); // [RL12]

  property p_dma_cs;
    @(posedge clock) disable iff (!rst_n)
    ev && dmack && (cb || ctl || both_cs) |=> !dma_rd && !dma_wr && host_fault;
  endproperty
  a_dma_cs: assert property (p_dma_cs) else $error("dma strobe with select"); // [RL13]

  property p_dma_idle;
    @(posedge clock) disable iff (!rst_n)
    ev && dmack && !cb && !ctl && !both_cs && (dmarq_released || (!dmarq_on && idle))
      |=> !dma_rd && !dma_wr;
  endproperty
  a_dma_idle: assert property (p_dma_idle) else $error("ignored dma strobe moved"); // [RL10]

endmodule // tfad_decode

// ---- hw/tfad_pkg.sv ----
/*
  Constants for the task-file access decoder: pin bit positions in the
  synchroniser vector, register addresses, status bit positions, reset values.
  Assumes one 50 MHz clock and an asynchronous active-low reset.
*/
// Function
// [RL1] Cylinder High read when idle returns stored value
// [RL2] Busy: reads give Status, writes are dropped
// [RL3] Device/Head write when idle updates, reselects device
// [RL4] Write during data request is dropped as fault
// [RL5] Device/Head read when idle returns stored value
// [RL6] Command write when idle loads, starts, clears pending
// [RL7] Busy/DRQ: command dropped unless device reset supported
// [RL8] Status read always returns Status, clears pending (here zero, pending kept, when Device 0 answers for absent Device 1)
// [RL9] Both chip selects asserted without DMACK: ignore strobe
// [RL10] DMA strobe with DMARQ released/negated idle: ignore
// [RL11] One trailing strobe ends a Multiword DMA burst
// [RL12] DMA strobe with DMARQ, busy or DRQ moves word
// [RL13] Chip select during DMACK: strobe ignored
// [RL14] Selected only when DEV bit equals own number
// [RL15] Device 0 takes Device Control for absent Device 1
// [RL16] Data address with DRQ moves one PIO word
// [RL17] Error/Features read returns Error, not Features
package tfad_pkg;
  // Positions inside the synchronised pin vector
  localparam int TFAD_B_CS0 = 23;
  localparam int TFAD_B_CS1 = 22;
  localparam int TFAD_B_DA = 19;
  localparam int TFAD_B_DIOR = 18;
  localparam int TFAD_B_DIOW = 17;
  localparam int TFAD_B_DMACK = 16;
  // Pins idle: every active-low strobe negated
  localparam logic [23:0] TFAD_SYNC_RST = 24'hFFFFFF;
  // Register addresses (DA2..DA0)
  localparam logic [2:0] TFAD_A_DATA = 3'h0;
  localparam logic [2:0] TFAD_A_ERRFEAT = 3'h1;
  localparam logic [2:0] TFAD_A_CYLHI = 3'h5;
  localparam logic [2:0] TFAD_A_DEVHEAD = 3'h6;
  localparam logic [2:0] TFAD_A_CMDSTAT = 3'h7;
  localparam logic [2:0] TFAD_A_DEVCTL = 3'h6;
  // Bit positions
  localparam int TFAD_ST_BSY = 7;
  localparam int TFAD_ST_DRQ = 3;
  localparam int TFAD_DH_DEV = 4;
  localparam int TFAD_DC_SRST = 2;
  localparam int TFAD_DC_NIEN = 1;
  // Command code of DEVICE RESET
  localparam logic [7:0] TFAD_CMD_DEVRST = 8'h08;
  // Reset values
  localparam logic [7:0] TFAD_REG_RST = 8'h00;
  localparam logic [15:0] TFAD_ZERO_WORD = 16'h0000;
endpackage

// ---- test/tfad_host.sv ----
/*
  Host adapter model: drives selects, address, strobes and DMA acknowledge.
  Assumes the bench resolves the data bus and that calls start after an edge.
*/
`timescale 1ns/1ps
module tfad_host (
  // Clock
  input wire logic clock,
  // Host pins towards the device
  output logic cs0_n,
  output logic cs1_n,
  output logic [2:0] da,
  output logic dior_n,
  output logic diow_n,
  output logic dmack_n,
  output logic [15:0] dd_h,
  // Resolved data bus
  input wire logic [15:0] dd
);
  // Everything negated from time zero
  initial
  begin
    cs0_n = 1'b1;
    cs1_n = 1'b1;
    da = 3'h0;
    dior_n = 1'b1;
    diow_n = 1'b1;
    dmack_n = 1'b1;
    dd_h = 16'h0000;
  end

  // One cycle: 4 clocks setup, 6 low, 5 hold, so the synchroniser sees it all
  task automatic xfer(input logic rd, input logic c0, input logic c1,
    input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clock);
    #1 cs0_n = c0;
    cs1_n = c1;
    da = a;
    dd_h = rd ? ~dd_h : d; // Released bus shows a changed pattern
    repeat (4) @(posedge clock);
    #1 dior_n = !rd;
    diow_n = rd;
    repeat (6) @(posedge clock);
    #1 q = dd;
    dior_n = 1'b1;
    diow_n = 1'b1;
    repeat (5) @(posedge clock);
    #1 cs0_n = 1'b1;
    cs1_n = 1'b1;
    dd_h = ~dd_h; // Hold time over: stale value must not linger
  endtask

  // Acknowledge is only changed between cycles, selects stay negated
  task automatic dack(input logic v);
    @(posedge clock);
    #1 dmack_n = v;
  endtask
endmodule // tfad_host

// ---- test/tfad_decode_tb.sv ----
/*
  Self-checking bench for the task-file decoder, using the host model.
  Assumes the design package and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tfad_decode_tb;
  import tfad_pkg::*;
  logic clock, rst_n, cs0_n, cs1_n, dior_n, diow_n, dmack_n, dd_oe_n;
  logic dmarq_on, dmarq_released, int_req, dev_num, dev1_absent, devrst_supported;
  logic nien, srst, selected, int_pending, cmd_start, pio_rd, pio_wr, dma_rd, dma_wr;
  logic host_fault;
  logic [2:0] da;
  logic [7:0] status_in, error_in, cyl_high, dev_head, features, command;
  logic [15:0] dd_h, dd_out, dd_in, wr_word, rd_word, q;
  int n_mismatch, check_count, n_cmd, n_pio, n_dma, n_flt;
  // Device wins the bus while it drives
  assign dd_in = dd_oe_n ? dd_h : dd_out;

  tfad_host u_host (.clock(clock), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .dior_n(dior_n),
    .diow_n(diow_n), .dmack_n(dmack_n), .dd_h(dd_h), .dd(dd_in));
  tfad_decode u_dut (.clock(clock), .rst_n(rst_n), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da),
    .dior_n(dior_n), .diow_n(diow_n), .dmack_n(dmack_n), .dd_in(dd_in), .dd_out(dd_out),
    .dd_oe_n(dd_oe_n), .status_in(status_in), .error_in(error_in), .dmarq_on(dmarq_on),
    .dmarq_released(dmarq_released), .rd_word(rd_word), .int_req(int_req),
    .dev_num(dev_num), .dev1_absent(dev1_absent), .devrst_supported(devrst_supported),
    .cyl_high(cyl_high), .dev_head(dev_head), .features(features), .command(command),
    .nien(nien), .srst(srst), .selected(selected), .int_pending(int_pending),
    .cmd_start(cmd_start), .pio_rd(pio_rd), .pio_wr(pio_wr), .dma_rd(dma_rd),
    .dma_wr(dma_wr), .host_fault(host_fault), .wr_word(wr_word));

  // 20 ns clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Pulses last one cycle, so they are tallied here
  always @(posedge clock)
  begin
    n_cmd += int'(cmd_start === 1'b1);
    n_pio += int'(pio_wr === 1'b1 || pio_rd === 1'b1);
    n_dma += int'(dma_rd === 1'b1 || dma_wr === 1'b1);
    n_flt += int'(host_fault === 1'b1);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic c0, input logic c1, input logic [2:0] a, input logic [15:0] d);
    u_host.xfer(1'b0, c0, c1, a, d, q);
  endtask

  task automatic rd(input logic c0, input logic c1, input logic [2:0] a,
    input logic [15:0] exp);
    u_host.xfer(1'b1, c0, c1, a, 16'h0000, q);
    chk(q, exp);
  endtask

  // Core state, changed just after an edge
  task automatic core(input logic [7:0] s, input logic on, input logic rel);
    status_in = s;
    dmarq_on = on;
    dmarq_released = rel;
  endtask

  task automatic irq;
    @(posedge clock);
    #1 int_req = 1'b1;
    @(posedge clock);
    #1 int_req = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'b0;
    core(8'h00, 1'b0, 1'b0);
    error_in = 8'hE5;
    rd_word = 16'hBEEF;
    int_req = 1'b0;
    dev_num = 1'b0;
    dev1_absent = 1'b0;
    devrst_supported = 1'b0;
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clock);
    // Idle register traffic and selection
    wr(1'b0, 1'b1, TFAD_A_CYLHI, 16'h005A);
    rd(1'b0, 1'b1, TFAD_A_CYLHI, 16'h005A);
    wr(1'b0, 1'b1, TFAD_A_ERRFEAT, 16'h0011);
    rd(1'b0, 1'b1, TFAD_A_ERRFEAT, 16'h00E5);
    chk({8'h00, features}, 16'h0011);
    wr(1'b0, 1'b1, TFAD_A_DEVHEAD, 16'h00A0);
    rd(1'b0, 1'b1, TFAD_A_DEVHEAD, 16'h00A0);
    wr(1'b0, 1'b1, TFAD_A_DEVHEAD, 16'h0010);
    chk(16'(selected), 16'h0000);
    wr(1'b0, 1'b1, TFAD_A_DEVHEAD, 16'h0000);
    chk(16'(selected), 16'h0001);
    // Busy and data-request refusals
    core(8'h80, 1'b0, 1'b0);
    rd(1'b0, 1'b1, TFAD_A_CYLHI, 16'h0080);
    wr(1'b0, 1'b1, TFAD_A_CYLHI, 16'h0033);
    core(8'h08, 1'b0, 1'b0);
    wr(1'b0, 1'b1, TFAD_A_CYLHI, 16'h0044);
    chk(16'(n_flt), 16'h0001);
    core(8'h00, 1'b0, 1'b0);
    rd(1'b0, 1'b1, TFAD_A_CYLHI, 16'h005A);
    // Commands and interrupt pending
    irq();
    wr(1'b0, 1'b1, TFAD_A_CMDSTAT, 16'h0020);
    chk({command, 7'h00, int_pending}, 16'h2000);
    chk(16'(n_cmd), 16'h0001);
    core(8'h80, 1'b0, 1'b0);
    irq();
    wr(1'b0, 1'b1, TFAD_A_CMDSTAT, 16'h0030);
    chk({command, 7'h00, int_pending}, 16'h2001);
    devrst_supported = 1'b1;
    wr(1'b0, 1'b1, TFAD_A_CMDSTAT, {8'h00, TFAD_CMD_DEVRST});
    chk({command, 7'h00, int_pending}, 16'h0800);
    irq();
    rd(1'b0, 1'b1, TFAD_A_CMDSTAT, 16'h0080);
    chk(16'(int_pending), 16'h0000);
    // Both selects asserted without acknowledge
    core(8'h00, 1'b0, 1'b0);
    wr(1'b0, 1'b0, TFAD_A_CYLHI, 16'h0066);
    rd(1'b0, 1'b1, TFAD_A_CYLHI, 16'h005A);
    // PIO word under data request
    core(8'h08, 1'b0, 1'b0);
    wr(1'b0, 1'b1, TFAD_A_DATA, 16'hC0DE);
    chk(16'(n_pio), 16'h0001);
    chk(wr_word, 16'hC0DE);
    rd(1'b0, 1'b1, TFAD_A_DATA, 16'hBEEF);
    chk(16'(n_pio), 16'h0002);
    // Multiword DMA burst, idle strobe refused, trailing word, then refused strobes
    u_host.dack(1'b0);
    core(8'h80, 1'b1, 1'b0);
    wr(1'b1, 1'b1, TFAD_A_DATA, 16'h1234);
    chk(wr_word, 16'h1234);
    rd(1'b1, 1'b1, TFAD_A_DATA, 16'hBEEF);
    core(8'h08, 1'b1, 1'b0);
    wr(1'b1, 1'b1, TFAD_A_DATA, 16'h4321);
    chk(16'(n_dma), 16'h0003);
    core(8'h00, 1'b0, 1'b0);
    wr(1'b1, 1'b1, TFAD_A_DATA, 16'h1111);
    chk(wr_word, 16'h4321);
    core(8'h80, 1'b0, 1'b0);
    wr(1'b1, 1'b1, TFAD_A_DATA, 16'h5678);
    chk(wr_word, 16'h5678);
    wr(1'b1, 1'b1, TFAD_A_DATA, 16'h9ABC);
    chk(16'(n_dma), 16'h0004);
    core(8'h80, 1'b1, 1'b1);
    wr(1'b1, 1'b1, TFAD_A_DATA, 16'h2222);
    core(8'h80, 1'b1, 1'b0);
    wr(1'b0, 1'b1, TFAD_A_DATA, 16'h3333); // Selects broken on purpose
    chk(16'(n_dma), 16'h0004);
    chk(16'(n_flt), 16'h0005);
    u_host.dack(1'b1);
    // Device 0 standing in for an absent device 1
    core(8'h00, 1'b0, 1'b0);
    dev1_absent = 1'b1;
    wr(1'b0, 1'b1, TFAD_A_DEVHEAD, 16'h0010);
    wr(1'b1, 1'b0, TFAD_A_DEVCTL, 16'h0006);
    chk(16'({srst, nien}), 16'h0003);
    wr(1'b1, 1'b0, TFAD_A_DEVCTL, 16'h0000);
    chk(16'({srst, nien}), 16'h0000);
    tally_and_finish();
  end
endmodule // tfad_decode_tb
